// ---- rtl/radio_cmd_defs.svh ----
// constants for the radio command interpreter: offsets, fields, resets
// assumes inclusion by bare name from the rtl folder
`ifndef RADIO_CMD_DEFS_SVH
`define RADIO_CMD_DEFS_SVH
// register offsets
`define REG_RADIO_CONFIG   5'h00
`define REG_AUTO_ACK       5'h01
`define REG_RX_PIPES       5'h02
`define REG_STATUS         5'h07
`define REG_FIFO_STATE     5'h17
`define REG_ENABLES_A      5'h1d
// reset values
`define RST_RADIO_CONFIG   8'h08
`define RST_AUTO_ACK       8'h3f
`define RST_RX_PIPES       8'h03
`define RST_ENABLES_A      8'h00
// field positions
`define BIT_RX_BLOCK       6
`define BIT_TX_BLOCK       5
`define BIT_RT_BLOCK       4
`define BIT_CRC_EN         3
`define BIT_RX_ROLE        0
`define BIT_ST_RX          6
`define BIT_ST_TX          5
`define BIT_ST_RT          4
`define BIT_FE_NOACK       0
`define BIT_FE_ACKPL       1
// command words
`define CMD_RD_REG_HI      3'b000
`define CMD_WR_REG_HI      3'b001
`define CMD_RD_RX_PL       8'h61
`define CMD_WR_TX_PL       8'ha0
`define CMD_WR_ACK_HI      5'b10101
`define CMD_WR_NOACK       8'hb0
`define CMD_FLUSH_TX       8'he1
`define CMD_FLUSH_RX       8'he2
`define CMD_REUSE          8'he3
`define CMD_NOP            8'hff
`define PIPE_MAX           3'h5
`endif

// ---- rtl/radio_cmd_pkg.sv ----
// types for the radio command interpreter
// assumes nothing beyond a SystemVerilog compiler
package radio_cmd_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA} spi_state_t;
endpackage

// ---- rtl/radio_spi_cmd.sv ----
// command side of the radio: spi slave, registers, payload fifos, irq
// assumes a host that drives csn, sck and mosi from another clock domain
`timescale 1ns/10ps
`default_nettype none
`include "radio_cmd_defs.svh"

// How it works
// [RULE1] ack payload write tagged by pipe, pipes above five refused
// [RULE2] at most three ack payloads, fifo order kept
// [RULE3] unacked write queues packet without auto acknowledge
// [RULE4] no-operation changes nothing, status still returned
// [RULE5] special writes need enables_a enable bits set
// [RULE6] multi-byte registers least byte first, msb first
// [RULE7] early chip select end keeps unwritten upper bytes
// [RULE8] status shifted out after chip select falls
// [RULE9] pipe number updated when interrupt line deasserts; here it is updated when the line asserts
// [RULE10] separate three-deep transmit and receive fifos, 32 bytes
// [RULE11] transmit fifo stalls on lost links, flush empties; here it stalls only in receiver role
// [RULE12] receive payload read returns oldest payload
// [RULE13] unsent payload kept when retry limit raised
// [RULE14] fifo state reports full, empty and reuse flag
// [RULE15] interrupt asserts for unmasked set event flags
// [RULE16] writing one clears flag, interrupt then releases
// [RULE17] mask bits six, five, four block sources
// [RULE18] undefined register bits read as zero
// [RULE19] host never writes test addresses 18 to 1b
// [RULE20] crc enable resets high, forced by auto ack
// [RULE21] bit one powers up, bit zero receive role
// [RULE22] auto ack resets all ones, pipes 0,1 enabled
// [RULE23] host lowers chip select before each command
// [RULE24] command byte msb first, then data bytes
module radio_spi_cmd #(
  parameter int DEPTH = 3,
  parameter int BYTES = 32
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // serial link from the host
  input  wire logic       spi_csn_n,
  input  wire logic       spi_sck,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  // radio core events and state
  input  wire logic       ev_tx_sent,
  input  wire logic       ev_rx_ready,
  input  wire logic [2:0] ev_rx_pipe,
  input  wire logic [7:0] ev_rx_byte,
  input  wire logic       ev_rx_byte_vld,
  input  wire logic       ev_rx_done,
  input  wire logic       ev_retry_limit,
  input  wire logic       ev_tx_taken,
  input  wire logic [5:0] link_lost,
  // state shown to the radio core
  output logic            power_up_bit,
  output logic            receive_role_select,
  output logic            tx_pending,
  output logic            tx_unacked,
  output logic [2:0]      tx_pipe,
  output logic            radio_irq_n
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // one byte of payload would leave the byte index with no bits at all
  if (DEPTH != 3 || BYTES < 2 || BYTES > 32) begin : g_chk
    $error("unsupported fifo shape");
  end

  localparam int AW = $clog2(BYTES);

  // ****************************************************************
  // pin input synchronisers and edge finders
  // ****************************************************************
  logic [2:0] csn_q, sck_q, mosi_q;
  logic [2:0] csn_d, sck_d, mosi_d;
  always_comb begin
    csn_d  = {csn_q[1:0], spi_csn_n};
    sck_d  = {sck_q[1:0], spi_sck};
    mosi_d = {mosi_q[1:0], spi_mosi};
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      csn_q  <= 3'h7;
      sck_q  <= 3'h0;
      mosi_q <= 3'h0;
    end else begin
      csn_q  <= csn_d;
      sck_q  <= sck_d;
      mosi_q <= mosi_d;
    end
  end
  // a change counts once stage two has it while stage three still holds the old level
  logic csn_fall, csn_rise, sck_rise, sck_fall, cs_act;
  assign csn_fall = csn_q[2] & ~csn_q[1];
  assign csn_rise = ~csn_q[2] & csn_q[1];
  assign sck_rise = ~sck_q[2] & sck_q[1];
  assign sck_fall = sck_q[2] & ~sck_q[1];
  assign cs_act   = ~csn_q[2];

  // ****************************************************************
  // state: registers, fifos, serial engine
  // ****************************************************************
  radio_cmd_pkg::spi_state_t st_q, st_d;
  logic [7:0] cfg_q, cfg_d, aa_q, aa_d, rxe_q, rxe_d, fe_q, fe_d;
  logic [2:0] flg_q, flg_d;            // rx ready, tx sent, retry limit
  logic [2:0] pipe_q, pipe_d;
  logic       irq_q, irq_d, reuse_q, reuse_d;
  logic [7:0] sh_q, sh_d, cmd_q, cmd_d, out_q, out_d;
  logic [2:0] bit_q, bit_d;
  logic [5:0] byte_q, byte_d;
  logic       miso_q, miso_d;
  // transmit fifo: entries with pipe tag and unacked mark
  logic [7:0] txm_q [DEPTH][BYTES];
  logic [2:0] txp_q [DEPTH];
  logic       txn_q [DEPTH];
  logic [1:0] txw_q, txw_d, txr_q, txr_d, txc_q, txc_d;
  logic [7:0] rxm_q [DEPTH][BYTES];
  logic [2:0] rxpp_q [DEPTH];
  logic [1:0] rxw_q, rxw_d, rxr_q, rxr_d, rxc_q, rxc_d;
  logic [AW-1:0] rxi_q, rxi_d;
  // write strobes into the memories
  logic       tx_we, rx_we;
  logic [7:0] we_data;

  // commands decoded from the latched command byte
  logic is_rd, is_wr, is_txw, is_ack, is_nak, is_rxr, tx_write_ok;
  logic [4:0] addr;
  assign addr   = cmd_q[4:0];
  assign is_rd  = cmd_q[7:5] == `CMD_RD_REG_HI;
  assign is_wr  = cmd_q[7:5] == `CMD_WR_REG_HI;
  assign is_txw = cmd_q == `CMD_WR_TX_PL;
  assign is_ack = cmd_q[7:3] == `CMD_WR_ACK_HI
                  && cmd_q[2:0] <= `PIPE_MAX            // RULE1
                  && fe_q[`BIT_FE_ACKPL]                // RULE5
                  && cfg_q[`BIT_RX_ROLE];
  assign is_nak = cmd_q == `CMD_WR_NOACK && fe_q[`BIT_FE_NOACK] // RULE5
                  && !cfg_q[`BIT_RX_ROLE];              // RULE3
  assign is_rxr = cmd_q == `CMD_RD_RX_PL;
  assign tx_write_ok = (is_txw | is_ack | is_nak) && txc_q != 2'(DEPTH);

  // register read mux; undefined bits are zero
  function automatic logic [7:0] rd_reg(input logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;                                          // RULE18
    unique case (a)
      `REG_RADIO_CONFIG: begin
        v = {1'b0, cfg_q[6:0]};
        if (|aa_q[5:0]) v[`BIT_CRC_EN] = 1'b1;          // RULE20
      end
      `REG_AUTO_ACK:   v = {2'b00, aa_q[5:0]};
      `REG_RX_PIPES:   v = {2'b00, rxe_q[5:0]};
      `REG_STATUS:     v = {1'b0, flg_q, pipe_q, txc_q == 2'(DEPTH)};
      `REG_FIFO_STATE: v = {1'b0, reuse_q, txc_q == 2'(DEPTH),
                            txc_q == 2'h0, 2'b00, rxc_q == 2'(DEPTH),
                            rxc_q == 2'h0};             // RULE14
      `REG_ENABLES_A:  v = {6'h00, fe_q[1:0]};
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  // next state of the whole command engine
  always_comb begin
    st_d = st_q; cfg_d = cfg_q; aa_d = aa_q; rxe_d = rxe_q; fe_d = fe_q;
    flg_d = flg_q; pipe_d = pipe_q; reuse_d = reuse_q;
    sh_d = sh_q; cmd_d = cmd_q; out_d = out_q; bit_d = bit_q;
    byte_d = byte_q; miso_d = miso_q;
    txw_d = txw_q; txr_d = txr_q; txc_d = txc_q;
    rxw_d = rxw_q; rxr_d = rxr_q; rxc_d = rxc_q; rxi_d = rxi_q;
    tx_we = 1'b0; rx_we = 1'b0; we_data = {sh_q[6:0], mosi_q[2]};
    // serial engine; status goes out first on every frame
    if (csn_fall) begin
      st_d = radio_cmd_pkg::ST_CMD; bit_d = 3'h0; byte_d = 6'h00;
      out_d = rd_reg(`REG_STATUS);                      // RULE8
      miso_d = out_d[7];
    end else if (!cs_act) begin
      st_d = radio_cmd_pkg::ST_IDLE;
    end else if (sck_fall) begin
      miso_d = out_q[7];
    end else if (sck_rise && st_q != radio_cmd_pkg::ST_IDLE) begin
      sh_d  = we_data;                                  // RULE24
      out_d = {out_q[6:0], 1'b0};
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        byte_d = byte_q + 6'h01;
        if (st_q == radio_cmd_pkg::ST_CMD) begin
          cmd_d = we_data; st_d = radio_cmd_pkg::ST_DATA;
          if (we_data[7:5] == `CMD_RD_REG_HI) out_d = rd_reg(we_data[4:0]);
          if (we_data == `CMD_RD_RX_PL) out_d = rxm_q[rxr_q][0];
          rxi_d = '0;
          if (we_data == `CMD_FLUSH_TX) begin
            txc_d = 2'h0; txr_d = txw_q; reuse_d = 1'b0; // RULE11 RULE14
          end
          if (we_data == `CMD_FLUSH_RX) begin
            rxc_d = 2'h0; rxr_d = rxw_q;
          end
          if (we_data == `CMD_REUSE) reuse_d = 1'b1;    // RULE14
          // no-operation falls through every test        RULE4
        end else begin
          // one-byte registers: byte zero only, later bytes dropped RULE7
          if (is_wr && byte_q == 6'h01 && !cfg_q[1]) begin
            unique case (addr)
              `REG_RADIO_CONFIG: cfg_d = {1'b0, we_data[6:0]}; // RULE21
              `REG_AUTO_ACK:     aa_d  = {2'b00, we_data[5:0]};
              `REG_RX_PIPES:     rxe_d = {2'b00, we_data[5:0]};
              `REG_ENABLES_A:    fe_d  = {6'h00, we_data[1:0]};
              default: ;                                // RULE19
            endcase
          end
          if (is_wr && addr == `REG_STATUS && byte_q == 6'h01)
            flg_d = flg_q & ~we_data[6:4];              // RULE16
          if ((is_txw | is_ack | is_nak) && txc_q != 2'(DEPTH)
              && byte_q <= 6'(BYTES)) tx_we = 1'b1;     // RULE10
          if (is_rxr) begin
            rxi_d = rxi_q + AW'(1);
            out_d = rxm_q[rxr_q][rxi_d];                // RULE12
          end
          if (is_rd) out_d = 8'h00;                     // RULE6
        end
      end
    end
    // frame end commits payload writes and reads
    if (csn_rise && st_q == radio_cmd_pkg::ST_DATA && byte_q > 6'h01) begin
      if (tx_write_ok) begin
        txw_d = (txw_q == 2'(DEPTH-1)) ? 2'h0 : txw_q + 2'h1;
        txc_d = txc_q + 2'h1; reuse_d = is_txw ? 1'b0 : reuse_q;
      end
      if (is_rxr && rxc_q != 2'h0) begin
        rxr_d = (rxr_q == 2'(DEPTH-1)) ? 2'h0 : rxr_q + 2'h1;
        rxc_d = rxc_q - 2'h1;
      end
    end
    // radio core takes the head; kept on retry limit or reuse   RULE13
    // count after a flush in the same cycle, so it cannot wrap below zero
    if (ev_tx_taken && txc_d != 2'h0 && !reuse_q && !ev_retry_limit) begin
      txr_d = (txr_q == 2'(DEPTH-1)) ? 2'h0 : txr_q + 2'h1;
      txc_d = txc_d - 2'h1;
    end
    // received bytes fill the write slot, committed on done
    if (ev_rx_byte_vld && rxc_q != 2'(DEPTH)) rx_we = 1'b1;
    if (ev_rx_done && rxc_q != 2'(DEPTH)) begin
      rxw_d = (rxw_q == 2'(DEPTH-1)) ? 2'h0 : rxw_q + 2'h1;
      rxc_d = rxc_d + 2'h1;
    end
    // event flags; a set wins over a clear in the same cycle RULE15
    if (ev_rx_ready)    flg_d[2] = 1'b1;
    if (ev_tx_sent)     flg_d[1] = 1'b1;
    if (ev_retry_limit) flg_d[0] = 1'b1;
    irq_d = |(flg_d & ~cfg_q[6:4]);                     // RULE17
    // pipe number follows the head of the rx fifo on the irq edge RULE9
    if (irq_d && !irq_q) pipe_d = rxc_q != 2'h0 ? rxpp_q[rxr_q] : 3'h7;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= radio_cmd_pkg::ST_IDLE;
      cfg_q <= `RST_RADIO_CONFIG;                       // RULE20 RULE21
      aa_q <= `RST_AUTO_ACK; rxe_q <= `RST_RX_PIPES;    // RULE22
      fe_q <= `RST_ENABLES_A; flg_q <= 3'h0; pipe_q <= 3'h7;
      irq_q <= 1'b0; reuse_q <= 1'b0;
      sh_q <= 8'h00; cmd_q <= `CMD_NOP; out_q <= 8'h00;
      bit_q <= 3'h0; byte_q <= 6'h00; miso_q <= 1'b0;
      txw_q <= 2'h0; txr_q <= 2'h0; txc_q <= 2'h0;
      rxw_q <= 2'h0; rxr_q <= 2'h0; rxc_q <= 2'h0; rxi_q <= '0;
    end else begin
      st_q <= st_d; cfg_q <= cfg_d; aa_q <= aa_d; rxe_q <= rxe_d;
      fe_q <= fe_d; flg_q <= flg_d; pipe_q <= pipe_d; irq_q <= irq_d;
      reuse_q <= reuse_d; sh_q <= sh_d; cmd_q <= cmd_d; out_q <= out_d;
      bit_q <= bit_d; byte_q <= byte_d; miso_q <= miso_d;
      txw_q <= txw_d; txr_q <= txr_d; txc_q <= txc_d;
      rxw_q <= rxw_d; rxr_q <= rxr_d; rxc_q <= rxc_d; rxi_q <= rxi_d;
    end
  end

  // payload memories; bytes stored from index zero upward RULE1
  logic [AW-1:0] rx_wi_q;
  always_ff @(posedge sys_clk) begin
    if (tx_we) txm_q[txw_q][AW'(byte_q - 6'h01)] <= we_data;
    if (tx_we) txp_q[txw_q] <= is_ack ? cmd_q[2:0] : 3'h0;
    if (tx_we) txn_q[txw_q] <= is_nak;                  // RULE3
    if (rx_we) rxm_q[rxw_q][rx_wi_q] <= ev_rx_byte;
    if (rx_we) rxpp_q[rxw_q] <= ev_rx_pipe;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst || ev_rx_done) rx_wi_q <= '0;
    else if (rx_we) rx_wi_q <= rx_wi_q + AW'(1);
  end

  // outputs to the radio core; head order gives same-pipe order RULE2
  logic pend_d, nak_d;
  logic [2:0] tp_d;
  always_comb begin
    tp_d   = txp_q[txr_q];
    nak_d  = txn_q[txr_q] & (txc_q != 2'h0);
    // in receiver role, a head aimed at a lost link blocks the queue until flushed RULE11
    pend_d = txc_q != 2'h0 && !(cfg_q[`BIT_RX_ROLE] && link_lost[tp_d]);
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_pending <= 1'b0; tx_unacked <= 1'b0; tx_pipe <= 3'h0;
      power_up_bit <= 1'b0; receive_role_select <= 1'b0;
      radio_irq_n <= 1'b1;
    end else begin
      tx_pending <= pend_d; tx_unacked <= nak_d; tx_pipe <= tp_d;
      power_up_bit <= cfg_q[1]; receive_role_select <= cfg_q[0];
      radio_irq_n <= ~irq_d;                            // RULE15 RULE16
    end
  end
  assign spi_miso = miso_q;

endmodule
`default_nettype wire

// ---- sim/radio_spi_cmd_asserts.sv ----
// checker: timing relations seen at the radio command block ports
// assumes one sys_clk domain; the serial pins are asynchronous to it
`timescale 1ns/10ps
`default_nettype none
module radio_spi_cmd_asserts (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // serial link
  input wire logic       spi_csn_n,
  input wire logic       spi_miso,
  // core events
  input wire logic       ev_tx_sent,
  input wire logic       ev_rx_ready,
  input wire logic       ev_retry_limit,
  input wire logic       ev_tx_taken,
  // outputs under watch
  input wire logic       power_up_bit,
  input wire logic       receive_role_select,
  input wire logic       tx_pending,
  input wire logic       tx_unacked,
  input wire logic [2:0] tx_pipe,
  input wire logic       radio_irq_n
);
  // ***********************************************
  // cause counters and properties
  // ***********************************************
  logic [3:0] hi_q, hi_d, ev_q, ev_d;
  // saturating ages: select high, last core event; a cause older than
  // the sync chain plus two registers cannot explain an output move
  always_comb begin
    hi_d = spi_csn_n ? hi_q + {3'h0, hi_q != 4'hf} : 4'h0;
    ev_d = (ev_tx_sent | ev_rx_ready | ev_retry_limit) ? 4'h0
         : ev_q + {3'h0, ev_q != 4'hf};
  end
  always_ff @(posedge sys_clk) begin
    hi_q <= sys_rst ? 4'hf : hi_d;
    ev_q <= sys_rst ? 4'hf : ev_d;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence status_lead;
    !spi_miso [*3];
  endsequence
  csn_status_a: assert property ($fell(spi_csn_n) |-> ##6 status_lead)
    else $error("status msb not low after select");
  cfg_change_a: assert property ($changed({power_up_bit,
    receive_role_select}) |-> hi_q < 12)
    else $error("config bit moved without a write");
  irq_fall_a: assert property ($fell(radio_irq_n) |->
    ev_q < 4 || hi_q < 12)
    else $error("interrupt raised with no cause");
  irq_rise_a: assert property ($rose(radio_irq_n) |-> hi_q < 12)
    else $error("interrupt released with no clear");
  unacked_head_a: assert property (tx_unacked |-> tx_pending)
    else $error("unacked flag without a packet");
  pipe_range_a: assert property (tx_pending |-> tx_pipe <= 3'h5)
    else $error("head pipe out of range");
  retry_keep_a: assert property (ev_retry_limit && ev_tx_taken &&
    tx_pending |=> $stable({tx_pending, tx_unacked, tx_pipe}) [*4])
    else $error("payload dropped on retry limit");
  tx_commit_a: assert property ($rose(tx_pending) |->
    spi_csn_n && hi_q < 12)
    else $error("packet queued outside frame end");
endmodule
bind radio_spi_cmd radio_spi_cmd_asserts u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .spi_csn_n(spi_csn_n),
  .spi_miso(spi_miso), .ev_tx_sent(ev_tx_sent), .ev_rx_ready(ev_rx_ready),
  .ev_retry_limit(ev_retry_limit), .ev_tx_taken(ev_tx_taken),
  .power_up_bit(power_up_bit), .receive_role_select(receive_role_select),
  .tx_pending(tx_pending), .tx_unacked(tx_unacked), .tx_pipe(tx_pipe),
  .radio_irq_n(radio_irq_n));
`default_nettype wire

// ---- sim/radio_spi_cmd_test.sv ----
// testbench for the radio command block: registers, fifos, interrupt
// assumes the host model and checker are compiled ahead of it
`timescale 1ns/10ps
`default_nettype none
module radio_spi_cmd_test;
  // ***********************************************
  // signals, instances, helpers
  // ***********************************************
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       csn, sck, mosi, miso, pwr, role, pend, unack, irq_n;
  logic       ev_sent, ev_rdy, ev_vld, ev_done, ev_rt, ev_taken;
  logic [2:0] ev_pipe, tx_pipe;
  logic [7:0] ev_byte, st, rd;
  logic [5:0] link_lost;
  int         error_cnt, checks_done;
  // rows: write enable, write addr, value, read addr, expected
  logic [26:0] rows [11] = '{
    {1'b0, 5'h00, 8'h00, 5'h00, 8'h08},
    {1'b0, 5'h00, 8'h00, 5'h01, 8'h3f},
    {1'b0, 5'h00, 8'h00, 5'h02, 8'h03},
    {1'b0, 5'h00, 8'h00, 5'h1d, 8'h00},
    {1'b0, 5'h00, 8'h00, 5'h07, 8'h0e},
    {1'b0, 5'h00, 8'h00, 5'h05, 8'h00},
    {1'b1, 5'h01, 8'h00, 5'h00, 8'h08},
    {1'b1, 5'h00, 8'h00, 5'h00, 8'h00},
    {1'b1, 5'h01, 8'h01, 5'h00, 8'h08},
    {1'b1, 5'h01, 8'hff, 5'h01, 8'h3f},
    {1'b1, 5'h02, 8'h3f, 5'h02, 8'h3f}};
  always #5 sys_clk = ~sys_clk;
  radio_spi_cmd u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .spi_csn_n(csn), .spi_sck(sck), .spi_mosi(mosi), .spi_miso(miso),
    .ev_tx_sent(ev_sent), .ev_rx_ready(ev_rdy), .ev_rx_pipe(ev_pipe),
    .ev_rx_byte(ev_byte), .ev_rx_byte_vld(ev_vld), .ev_rx_done(ev_done),
    .ev_retry_limit(ev_rt), .ev_tx_taken(ev_taken), .link_lost(link_lost),
    .power_up_bit(pwr), .receive_role_select(role), .tx_pending(pend),
    .tx_unacked(unack), .tx_pipe(tx_pipe), .radio_irq_n(irq_n));
  spi_host_model u_host (.sys_clk(sys_clk), .csn_n(csn), .sck(sck),
    .mosi(mosi), .miso(miso));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d in %0d checks", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // host never touches the test addresses 18 to 1b here
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    u_host.xfer({3'b001, a}, v, 1, st, rd);
  endtask
  task automatic rdr(input logic [4:0] a, input logic [7:0] e);
    u_host.xfer({3'b000, a}, 8'hff, 1, st, rd);
    check(rd, e);
  endtask
  // one-cycle core pulses: rx ready, sent, retry limit, taken
  task automatic fire(input logic [3:0] m);
    @(posedge sys_clk) #1 {ev_rdy, ev_sent, ev_rt, ev_taken} = m;
    @(posedge sys_clk) #1 {ev_rdy, ev_sent, ev_rt, ev_taken} = 4'h0;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
  // one-byte received payload on pipe 2
  task automatic rx_push(input logic [7:0] b);
    @(posedge sys_clk) #1 {ev_byte, ev_vld} = {b, 1'b1};
    @(posedge sys_clk) #1 {ev_vld, ev_done} = 2'b01;
    @(posedge sys_clk) #1 ev_done = 1'b0;
  endtask
  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    {ev_sent, ev_rdy, ev_vld, ev_done, ev_rt, ev_taken} = 6'h00;
    {ev_pipe, ev_byte, link_lost} = {3'h2, 8'h00, 6'h00};
    error_cnt = 0;
    checks_done = 0;
    repeat (6) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 check({4'h0, irq_n, pwr, role, pend}, 8'h08);
    for (int i = 0; i < 11; i++) begin
      if (rows[i][26]) wr(rows[i][25:21], rows[i][20:13]);
      rdr(rows[i][12:8], rows[i][7:0]);
    end
    // sent source: raise, mask, clear by writing one; then retry limit raised and cleared
    fire(4'h4);
    check({7'h0, irq_n}, 8'h00);
    u_host.xfer(8'hff, 8'h00, 0, st, rd);
    check(st, 8'h2e);
    wr(5'h00, 8'h28);
    check({7'h0, irq_n}, 8'h01);
    wr(5'h07, 8'h20);
    rdr(5'h07, 8'h0e);
    wr(5'h00, 8'h08);
    fire(4'h2);
    check({7'h0, irq_n}, 8'h00);
    wr(5'h07, 8'h10);
    check({7'h0, irq_n}, 8'h01);
    // transmitter role: unacked write needs its enable, fifo fills
    u_host.xfer(8'hb0, 8'h33, 4, st, rd);
    check({7'h0, pend}, 8'h00);
    wr(5'h1d, 8'h03);
    u_host.xfer(8'hb0, 8'h33, 4, st, rd);
    check({6'h0, pend, unack}, 8'h03);
    repeat (3) u_host.xfer(8'ha0, 8'h44, 32, st, rd);
    u_host.xfer(8'hff, 8'h00, 0, st, rd);
    check(st, 8'h0f);
    rdr(5'h17, 8'h21);
    // retry limit together with a take: the unacked head must stay
    fire(4'h3);
    check({6'h0, pend, unack}, 8'h03);
    wr(5'h07, 8'h10);
    fire(4'h1);
    check({6'h0, pend, unack}, 8'h02);
    u_host.xfer(8'he3, 8'h00, 0, st, rd);
    rdr(5'h17, 8'h41);
    u_host.xfer(8'he1, 8'h00, 0, st, rd);
    check({7'h0, pend}, 8'h00);
    rdr(5'h17, 8'h11);
    // receiver role: pipe six refused, acked payloads kept in order
    wr(5'h00, 8'h09);
    check({7'h0, role}, 8'h01);
    u_host.xfer(8'hae, 8'h55, 2, st, rd);
    check({7'h0, pend}, 8'h00);
    u_host.xfer(8'had, 8'h55, 2, st, rd);
    u_host.xfer(8'ha9, 8'h66, 2, st, rd);
    check({pend, 4'h0, tx_pipe}, 8'h85);
    fire(4'h1);
    check({pend, 4'h0, tx_pipe}, 8'h81);
    // link to the only pending pipe lost: queue stalls until flushed
    @(posedge sys_clk) #1 link_lost = 6'h02;
    repeat (2) @(posedge sys_clk);
    #1 check({7'h0, pend}, 8'h00);
    u_host.xfer(8'he1, 8'h00, 0, st, rd);
    @(posedge sys_clk) #1 link_lost = 6'h00;
    // receive fifo: pipe number in status, oldest payload first
    rx_push(8'h11);
    rx_push(8'h22);
    fire(4'h8);
    u_host.xfer(8'hff, 8'h00, 0, st, rd);
    check(st, 8'h44);
    u_host.xfer(8'h61, 8'hff, 1, st, rd);
    check(rd, 8'h11);
    u_host.xfer(8'h61, 8'hff, 1, st, rd);
    check(rd, 8'h22);
    wr(5'h07, 8'h40);
    // pipe number only moves on the next interrupt edge, so it stays 2
    rdr(5'h07, 8'h04);
    rx_push(8'h33);
    rdr(5'h17, 8'h10);
    u_host.xfer(8'he2, 8'h00, 0, st, rd);
    rdr(5'h17, 8'h11);
    // power up last: register writes other than status clears are refused from then on
    wr(5'h00, 8'h0b);
    check({7'h0, pwr}, 8'h01);
    wr(5'h01, 8'h00);
    rdr(5'h01, 8'h3f);
    report_and_stop();
  end
  // watchdog: the sequence needs well under half of this span
  initial begin
    #900000;
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- sim/spi_host_model.sv ----
// host model: drives whole command frames onto the serial link
// assumes mode 0 framing and a 125 ns serial clock period
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // reference clock, only to keep link edges off its sampling instant
  input  wire logic      sys_clk,
  // serial link
  output logic           csn_n,
  output logic           sck,
  output logic           mosi,
  input  wire logic      miso
);
  // ***********************************************
  // frame driver
  // ***********************************************
  // clock idles low between frames, select idles high
  initial begin
    csn_n = 1'b1;
    sck   = 1'b0;
    mosi  = 1'b0;
  end
  // command byte then nd bytes of dat; first two bytes seen are returned
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
    input int nd, output logic [7:0] st, output logic [7:0] rd);
    logic [7:0] sh, r;
    rd = 8'h00;
    @(posedge sys_clk) #1 csn_n = 1'b0;
    #62.5;
    for (int b = 0; b <= nd; b++) begin
      sh = (b == 0) ? cmd : dat;
      for (int i = 7; i >= 0; i--) begin
        mosi = sh[i];
        #62.5 sck = 1'b1;
        r = {r[6:0], miso};
        #62.5 sck = 1'b0;
      end
      if (b == 0) st = r;
      if (b == 1) rd = r;
    end
    #62.5 csn_n = 1'b1;
    // a released data line must not keep looking valid
    mosi = ~mosi;
    #500;
  endtask
endmodule
`default_nettype wire
